// file: logic/was_params.svh
`ifndef WAS_PARAMS_SVH
`define WAS_PARAMS_SVH
// How it works
// R1: Real-time records up to 15000 points.
// R2: Extended real-time records up to 30000 points.
// R3: Extended mode automatic when interval >= 100 ns.
// R4: Host writes 30000 length for longest record.
// R5: Reset-to-defaults selects real-time sampling.
// R6: Records fill serially from one trigger.
// R7: One shared parameter set for all channels.
// R8: Trigger point is record time zero.
// R9: Initiate applies setup, then awaits arm/trigger.
// R10: Pretrigger phase initialises and captures pretrigger points.
// R11: Trigger enabled after arm and pretrigger fill.
// R12: Posttrigger capture until record is full.
// R13: Complete records move to processing memory.
// R14: Normal cycle post-processes, then delivers results.
// R15: Auto-advance rearms directly until count reached.
// R16: Normal mode stores one raw sample per interval.
// R17: Average mode keeps results in floating point.
// R18: Peak-detect gives max/min per interval pair.
// R19: Envelope keeps highest and lowest across acquisitions.
// R20: Acquisition mode applies to all channels.
// R21: Combining finishes before record leaves acquisition.
// R22: Each channel has its own sample stream.
// R23: Combine count is 1 to 4096.
// R24: Restart discards accumulated averages and envelopes.
// R25: Combining modes unusable under auto-advance.
// R26: Auto-advance timestamps records at 125 ns.
// R27: Max then min in consecutive record positions.
`define WAS_NCH 4
`define WAS_SW 8
`define WAS_DW 20
`define WAS_MW 16
`define WAS_EW 4
`define WAS_AW 15
`define WAS_CW 13
`define WAS_IW 32
`define WAS_RCW 16
`define WAS_TW 8
`define WAS_MEM_DEPTH 30000
`define WAS_FIFO_DEPTH 16
`define WAS_RT_MAX 15'h3A98
`define WAS_ERT_MAX 15'h7530
`define WAS_DEF_LEN 15'h03E8
`define WAS_ERT_MIN_NS 32'h00000064
`define WAS_CNT_MIN 13'h0001
`define WAS_CNT_MAX 13'h1000
`define WAS_AA_MIN 16'h0001
`define WAS_CH_ALL 4'hF
`define WAS_CLK_NS 8'h28
`define WAS_TS_RES_NS 8'h7D
`endif

// file: logic/was_pkg.sv
package was_pkg;
`include "was_params.svh"
   typedef enum logic [2:0] {
      st_idle = 3'b000,
      st_pre = 3'b001,
      st_trig = 3'b010,
      st_post = 3'b011,
      st_xfer = 3'b100,
      st_out = 3'b101
   } was_state_t;
   typedef enum logic [1:0] {
      md_norm = 2'b00,
      md_avg = 2'b01,
      md_peak = 2'b10,
      md_env = 2'b11
   } was_mode_t;
   typedef logic [`WAS_NCH-1:0][`WAS_SW-1:0] was_samp_t;
   typedef logic [`WAS_NCH-1:0][`WAS_DW-1:0] was_vals_t;
   typedef struct packed {
      logic [`WAS_IW-1:0] interval_ns;
      logic [`WAS_AW-1:0] rec_len;
      logic [`WAS_AW-1:0] pre_len;
      was_mode_t mode;
      logic auto_adv;
      logic [`WAS_CW-1:0] comb_cnt;
      logic [`WAS_RCW-1:0] aa_cnt;
      logic arm_en;
      logic [`WAS_NCH-1:0] ch_en;
   } was_cfg_t;
   typedef struct packed {
      logic last;
      logic [`WAS_AW-1:0] idx;
      was_vals_t val;
   } was_word_t;
   typedef struct packed {
      was_state_t st;
      was_cfg_t act;
      logic ext;
      logic [`WAS_AW-1:0] len;
      logic [`WAS_AW-1:0] pre;
      logic [`WAS_CW-1:0] cnt;
      logic [`WAS_AW-1:0] base;
      logic [`WAS_AW-1:0] wptr;
      logic [`WAS_AW-1:0] pfill;
      logic armed;
      logic [`WAS_AW-1:0] idx;
      logic ph;
      logic [`WAS_CW-1:0] acq_idx;
      logic [`WAS_RCW-1:0] rec_cnt;
      logic busy;
      logic done;
   } was_seq_st_t;
endpackage

// file: logic/was_fifo.sv
`timescale 1ns/100ps
module was_fifo #(
   parameter int W = 96,
   parameter int D = 16
)
(
   input logic sys_clk,
   input logic rst,
   input logic ce,
   input logic in_valid,
   output logic in_ready,
   input logic [W-1:0] in_data,
   output logic out_valid,
   input logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int PW = $clog2(D);
   typedef struct packed {
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [PW:0] cnt;
      logic ov;
      logic [W-1:0] od;
   } was_fifo_st_t;
   was_fifo_st_t s, n;
   logic [W-1:0] mem [0:D-1];
   logic push;
   logic load;

   // ==========================================
   // Pointers and show-ahead output register
   always_comb
   begin
      n = s;
      push = in_valid && in_ready;
      load = (s.cnt != '0) && (!s.ov || out_ready);
      if (push)
      begin
         n.wp = PW'(s.wp + 1'b1);
      end
      if (load)
      begin
         n.rp = PW'(s.rp + 1'b1);
         n.od = mem[s.rp];
         n.ov = 1'b1;
      end
      else if (out_ready)
      begin
         n.ov = 1'b0;
      end
      n.cnt = (PW+1)'(s.cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, load});
   end

   assign in_ready = s.cnt != (PW+1)'(D);
   assign out_valid = s.ov;
   assign out_data = s.od;

   always_ff @(posedge sys_clk)
   begin
      if (ce && push)
      begin
         mem[s.wp] <= in_data;
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         s <= '0;
      end
      else if (ce)
      begin
         s <= n;
      end
   end
endmodule

// file: logic/was_tstamp.sv
`timescale 1ns/100ps
`include "was_params.svh"
module was_tstamp
(
   input logic sys_clk,
   input logic rst,
   input logic ce,
   input logic clr,
   input logic mark,
   output logic [`WAS_IW-1:0] stamp
);
   typedef struct packed {
      logic [`WAS_TW-1:0] frac;
      logic [`WAS_IW-1:0] cnt;
      logic [`WAS_IW-1:0] stamp;
   } was_ts_st_t;
   was_ts_st_t s, n;
   logic [`WAS_TW-1:0] fsum;

   // ==========================================
   // Fractional 40 ns to 125 ns tick divider
   always_comb
   begin
      n = s;
      fsum = `WAS_TW'(s.frac + `WAS_CLK_NS);
      if (fsum >= `WAS_TS_RES_NS)
      begin
         n.frac = `WAS_TW'(fsum - `WAS_TS_RES_NS);
         n.cnt = `WAS_IW'(s.cnt + 1'b1);
      end
      else
      begin
         n.frac = fsum;
      end
      if (mark)
      begin
         n.stamp = n.cnt;
         n.cnt = '0;
      end
      if (clr)
      begin
         n = '0;
      end
   end

   assign stamp = s.stamp;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         s <= '0;
      end
      else if (ce)
      begin
         s <= n;
      end
   end
endmodule

// file: logic/was_acq_seq.sv
`timescale 1ns/100ps
`include "was_params.svh"
module was_acq_seq
(
   input logic sys_clk,
   input logic rst,
   input logic ce,
   input was_pkg::was_cfg_t cfg,
   input logic cmd_init,
   input logic cmd_defaults,
   input logic arm_in,
   input logic trig_in,
   input logic samp_valid,
   input was_pkg::was_samp_t samp,
   input logic out_ready,
   output logic out_valid,
   output was_pkg::was_word_t out_word,
   output logic busy,
   output was_pkg::was_state_t phase,
   output logic ext_mode,
   output logic [`WAS_AW-1:0] eff_len,
   output logic done,
   output logic [`WAS_IW-1:0] stamp
);
   import was_pkg::*;

   localparam was_cfg_t CFG_DEF = '{interval_ns: '0, rec_len: `WAS_DEF_LEN, pre_len: '0,
      mode: md_norm, auto_adv: 1'b0, comb_cnt: `WAS_CNT_MIN, aa_cnt: `WAS_AA_MIN,
      arm_en: 1'b0, ch_en: `WAS_CH_ALL};
   localparam was_seq_st_t SEQ_RST = '{st: st_idle, act: CFG_DEF, ext: 1'b0,
      len: `WAS_DEF_LEN, pre: '0, cnt: `WAS_CNT_MIN, base: '0, wptr: '0, pfill: '0,
      armed: 1'b0, idx: '0, ph: 1'b0, acq_idx: '0, rec_cnt: '0, busy: 1'b0, done: 1'b0};

   was_seq_st_t s, n;
   was_samp_t acq_mem [0:`WAS_MEM_DEPTH-1];
   was_vals_t dsp_mem [0:`WAS_MEM_DEPTH-1];
   was_samp_t ra_q, rb_q, samp_m;
   was_vals_t rd_q, dsp_in, raw_vals, out_vals;
   logic [`WAS_AW-1:0] ra_a, rb_a, pj, acq_wa, lim;
   logic acq_we, dsp_we, push_v, push_rdy, tmark, last;
   was_word_t push_w;

   // ==========================================
   // Helpers
   function automatic logic [`WAS_AW-1:0] phys(input logic [`WAS_AW-1:0] i,
      input logic [`WAS_AW-1:0] pre, input logic [`WAS_AW-1:0] base);
      logic [`WAS_AW:0] sum;
      sum = {1'b0, i} + {1'b0, base};
      if (i >= pre)
         phys = i;
      else if (sum >= {1'b0, pre})
         phys = `WAS_AW'(sum - {1'b0, pre});
      else
         phys = sum[`WAS_AW-1:0];
   endfunction

   function automatic logic [`WAS_DW-1:0] comb(input was_mode_t m, input logic first,
      input logic odd, input logic [`WAS_SW-1:0] a, input logic [`WAS_SW-1:0] b,
      input logic [`WAS_DW-1:0] old);
      logic [`WAS_DW-1:0] ea, eb, pk;
      ea = `WAS_DW'(a);
      eb = `WAS_DW'(b);
      // Even slot keeps the maximum, odd slot the minimum [R27]
      pk = odd ? ((ea < eb) ? ea : eb) : ((ea > eb) ? ea : eb); // [R18]
      case (m)
         md_avg: comb = first ? ea : `WAS_DW'(old + ea); // [R17]
         md_peak, md_env:
            if (first)
               comb = pk;
            else
               comb = odd ? ((old < pk) ? old : pk) : ((old > pk) ? old : pk); // [R19]
         default: comb = ea; // [R16]
      endcase
   endfunction

   function automatic logic [`WAS_DW-1:0] fpack(input logic [`WAS_DW-1:0] x);
      logic [`WAS_DW-1:0] v;
      logic [`WAS_EW-1:0] e;
      v = x;
      e = '0;
      for (int k = 0; k < `WAS_EW; k++)
      begin
         if (v[`WAS_DW-1:`WAS_MW] != '0)
         begin
            v = v >> 1;
            e = `WAS_EW'(e + 1'b1);
         end
      end
      fpack = {e, v[`WAS_MW-1:0]};
   endfunction

   function automatic was_seq_st_t rearm(input was_seq_st_t x);
      rearm = x;
      rearm.st = st_pre;
      rearm.wptr = '0;
      rearm.pfill = '0;
      rearm.armed = 1'b0;
      rearm.idx = '0;
      rearm.ph = 1'b0;
   endfunction

   // ==========================================
   // Per-channel data paths
   always_comb
   begin
      for (int c = 0; c < `WAS_NCH; c++)
      begin
         samp_m[c] = s.act.ch_en[c] ? samp[c] : '0; // [R22]
         raw_vals[c] = `WAS_DW'(ra_q[c]);
         dsp_in[c] = comb(s.act.mode, s.acq_idx == '0, s.idx[0], ra_q[c], rb_q[c],
            rd_q[c]); // [R20]
         out_vals[c] = (s.act.mode == md_avg) ? fpack(rd_q[c]) : rd_q[c]; // [R17]
      end
   end

   // Pretrigger slots are unrolled oldest first [R8]
   assign pj = s.idx ^ `WAS_AW'(1);
   assign ra_a = phys(s.idx, s.pre, s.base);
   assign rb_a = phys((pj >= s.len) ? s.idx : pj, s.pre, s.base);
   assign last = s.idx == `WAS_AW'(s.len - 1'b1);

   // ==========================================
   // Sequencer
   always_comb
   begin
      n = s;
      n.done = 1'b0;
      acq_we = 1'b0;
      acq_wa = s.wptr;
      dsp_we = 1'b0;
      push_v = 1'b0;
      push_w = '0;
      tmark = 1'b0;
      lim = `WAS_RT_MAX;
      if (cmd_defaults)
      begin
         n = SEQ_RST; // [R5]
      end
      else if (cmd_init)
      begin
         n.act = cfg; // [R7] [R9]
         if (cfg.auto_adv)
         begin
            n.act.mode = md_norm; // [R25]
         end
         n.ext = cfg.interval_ns >= `WAS_ERT_MIN_NS; // [R3]
         lim = n.ext ? `WAS_ERT_MAX : `WAS_RT_MAX; // [R1] [R2]
         // Longest record only when the host asks for it [R4]
         n.len = (cfg.rec_len > lim) ? lim : ((cfg.rec_len == '0) ? `WAS_AW'(1) : cfg.rec_len);
         n.pre = (cfg.pre_len > n.len) ? n.len : cfg.pre_len;
         if (n.act.mode == md_norm || cfg.comb_cnt < `WAS_CNT_MIN)
            n.cnt = `WAS_CNT_MIN; // [R23]
         else if (cfg.comb_cnt > `WAS_CNT_MAX)
            n.cnt = `WAS_CNT_MAX; // [R23]
         else
            n.cnt = cfg.comb_cnt;
         n.acq_idx = '0; // [R24]
         n.rec_cnt = '0;
         n = rearm(n); // [R9]
      end
      else
      begin
         case (s.st)
            st_pre, st_trig:
            begin
               if (samp_valid && s.pre != '0 && !(s.st == st_trig && trig_in))
               begin
                  acq_we = 1'b1; // [R10]
                  n.wptr = (s.wptr == `WAS_AW'(s.pre - 1'b1)) ? '0 : `WAS_AW'(s.wptr + 1'b1);
                  if (s.pfill != s.pre)
                     n.pfill = `WAS_AW'(s.pfill + 1'b1);
               end
               if (arm_in)
               begin
                  n.armed = 1'b1;
               end
               if (s.st == st_pre && (s.armed || !s.act.arm_en) && s.pfill == s.pre)
               begin
                  n.st = st_trig; // [R11]
               end
               if (s.st == st_trig && trig_in)
               begin
                  // Trigger sample becomes record point pre, time zero [R8]
                  tmark = 1'b1;
                  n.base = s.wptr;
                  acq_wa = s.pre;
                  acq_we = samp_valid && s.pre != s.len;
                  n.idx = `WAS_AW'(s.pre + ((samp_valid && s.pre != s.len) ? 1'b1 : 1'b0));
                  n.st = st_post;
                  if (n.idx == s.len)
                  begin
                     n.st = st_xfer;
                     n.idx = '0;
                     n.ph = 1'b0;
                  end
               end
            end
            st_post:
            begin
               if (samp_valid)
               begin
                  acq_we = 1'b1; // [R6] [R12]
                  acq_wa = s.idx;
                  n.idx = `WAS_AW'(s.idx + 1'b1);
                  if (last)
                  begin
                     n.st = st_xfer;
                     n.idx = '0;
                     n.ph = 1'b0;
                  end
               end
            end
            st_xfer, st_out:
            begin
               push_v = s.ph && (s.st == st_out || s.act.auto_adv);
               push_w.last = last;
               push_w.idx = s.idx;
               push_w.val = (s.st == st_out) ? out_vals : raw_vals;
               dsp_we = s.ph && s.st == st_xfer && !s.act.auto_adv; // [R13] [R21]
               if (!s.ph)
               begin
                  n.ph = 1'b1;
               end
               else if (!push_v || push_rdy)
               begin
                  n.ph = 1'b0;
                  n.idx = `WAS_AW'(s.idx + 1'b1);
                  if (last)
                  begin
                     n.idx = '0;
                     if (s.st == st_out)
                     begin
                        n.st = st_idle; // [R14]
                        n.done = 1'b1;
                     end
                     else if (s.act.auto_adv)
                     begin
                        n.rec_cnt = `WAS_RCW'(s.rec_cnt + 1'b1); // [R15]
                        if (n.rec_cnt >= s.act.aa_cnt)
                        begin
                           n.st = st_idle;
                           n.done = 1'b1;
                        end
                        else
                        begin
                           n = rearm(n); // [R15]
                        end
                     end
                     else if (`WAS_CW'(s.acq_idx + 1'b1) == s.cnt)
                     begin
                        n.st = st_out; // [R14]
                     end
                     else
                     begin
                        n.acq_idx = `WAS_CW'(s.acq_idx + 1'b1);
                        n = rearm(n);
                     end
                  end
               end
            end
            default:
            begin
               n.st = st_idle;
            end
         endcase
      end
      n.busy = n.st != st_idle;
   end

   // ==========================================
   // Acquisition and processing memories
   always_ff @(posedge sys_clk)
   begin
      if (ce)
      begin
         if (acq_we)
            acq_mem[acq_wa] <= samp_m;
         if (dsp_we)
            dsp_mem[s.idx] <= dsp_in;
         ra_q <= acq_mem[ra_a];
         rb_q <= acq_mem[rb_a];
         rd_q <= dsp_mem[s.idx];
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
         s <= SEQ_RST;
      else if (ce)
         s <= n;
   end

   was_fifo #(.W($bits(was_word_t)), .D(`WAS_FIFO_DEPTH)) u_fifo (
      .sys_clk(sys_clk),
      .rst(rst),
      .ce(ce),
      .in_valid(push_v),
      .in_ready(push_rdy),
      .in_data(push_w),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data(out_word)
   );

   was_tstamp u_ts (
      .sys_clk(sys_clk),
      .rst(rst),
      .ce(ce),
      .clr(cmd_init),
      .mark(tmark && s.act.auto_adv), // [R26]
      .stamp(stamp)
   );

   assign busy = s.busy;
   assign phase = s.st;
   assign ext_mode = s.ext;
   assign eff_len = s.len;
   assign done = s.done;

   // ==========================================
   // Checks
   a_ext_auto: assert property (@(posedge sys_clk) disable iff (rst) // [R3]
      (ce && cmd_init && !cmd_defaults)
      |=> ext_mode == ($past(cfg.interval_ns) >= `WAS_ERT_MIN_NS))
      else $error("extended mode not derived from interval");
   a_rt_len: assert property (@(posedge sys_clk) disable iff (rst) // [R1]
      !ext_mode |-> eff_len <= `WAS_RT_MAX)
      else $error("real-time record too long");
   a_ert_len: assert property (@(posedge sys_clk) disable iff (rst) // [R2]
      ext_mode |-> eff_len <= `WAS_ERT_MAX)
      else $error("extended record too long");
   a_defaults_rt: assert property (@(posedge sys_clk) disable iff (rst) // [R5]
      (ce && cmd_defaults) |=> !ext_mode && phase == st_idle)
      else $error("defaults did not select real-time");
   a_trig_gate: assert property (@(posedge sys_clk) disable iff (rst) // [R11]
      phase == st_trig |-> s.pfill == s.pre && (s.armed || !s.act.arm_en))
      else $error("trigger enabled too early");
   a_post_fill: assert property (@(posedge sys_clk) disable iff (rst) // [R12]
      (ce && !cmd_init && !cmd_defaults && phase == st_post && samp_valid && !last)
      |=> phase == st_post && s.idx == $past(s.idx) + 1)
      else $error("posttrigger fill not serial");
   a_aa_plain: assert property (@(posedge sys_clk) disable iff (rst) // [R25]
      s.act.auto_adv |-> s.act.mode == md_norm)
      else $error("combining mode under auto-advance");
   a_init_restart: assert property (@(posedge sys_clk) disable iff (rst) // [R24]
      (ce && cmd_init && !cmd_defaults) |=> s.acq_idx == 0 && phase == st_pre && s.pfill == 0)
      else $error("initiate did not restart");
   a_cnt_range: assert property (@(posedge sys_clk) disable iff (rst) // [R23]
      s.cnt >= `WAS_CNT_MIN && s.cnt <= `WAS_CNT_MAX)
      else $error("combine count out of range");
   a_out_after: assert property (@(posedge sys_clk) disable iff (rst) // [R21]
      (phase == st_out) |-> !s.act.auto_adv && s.acq_idx + 1 == s.cnt)
      else $error("record left before combining ended");
   c_normal_done: cover property (@(posedge sys_clk) disable iff (rst)
      done && !s.act.auto_adv);
   c_aa_done: cover property (@(posedge sys_clk) disable iff (rst)
      done && s.act.auto_adv && s.rec_cnt > 1);
   c_avg_out: cover property (@(posedge sys_clk) disable iff (rst)
      phase == st_out && s.act.mode == md_avg && s.cnt > 1);
   c_fifo_stall: cover property (@(posedge sys_clk) disable iff (rst)
      push_v && !push_rdy);
endmodule

// file: tb/was_host.sv
`timescale 1ns/100ps
module was_host
import was_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic stall,
   input wire logic out_valid,
   output logic out_ready,
   input was_pkg::was_word_t out_word
);
   // ==========================================
   // Record sink: alternates ready, stops fully while stalled
   was_word_t got_q[$];
   logic tog_q;
   assign out_ready = ~stall & tog_q;
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         tog_q <= 1'b0;
      end
      else
      begin
         tog_q <= ~tog_q;
         if (out_valid && out_ready)
         begin
            got_q.push_back(out_word);
         end
      end
   end
endmodule

// file: tb/tb.sv
`timescale 1ns/100ps
`include "was_params.svh"
`define CHK(g, e, m) begin samples_checked++; if ((g) !== (e)) miss(m); end
module tb;
import was_pkg::*;
   logic sys_clk, rst, ce, cmd_init, cmd_defaults, arm_in, trig_in, samp_valid, stall;
   logic out_ready, out_valid, busy, ext_mode, done;
   was_cfg_t cfg;
   was_samp_t samp;
   was_word_t out_word;
   was_state_t phase;
   logic [`WAS_AW-1:0] eff_len;
   logic [`WAS_IW-1:0] stamp;
   int err_total = 0, samples_checked = 0, cyc = 0, dones = 0;
   longint tprev = 0, tdiff = 0, tsns = 0;
   wire [19:0] ctl_out = {busy, phase, ext_mode, eff_len};
   localparam logic [19:0] CTL_IDLE = {1'b0, st_idle, 1'b0, `WAS_DEF_LEN};
   int iv[3] = '{99, 100, 100};
   int ln[3] = '{20000, 30000, 31000};

   was_acq_seq dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .cfg(cfg), .cmd_init(cmd_init),
      .cmd_defaults(cmd_defaults), .arm_in(arm_in), .trig_in(trig_in),
      .samp_valid(samp_valid), .samp(samp), .out_ready(out_ready), .out_valid(out_valid),
      .out_word(out_word), .busy(busy), .phase(phase), .ext_mode(ext_mode),
      .eff_len(eff_len), .done(done), .stamp(stamp));
   was_host host (.sys_clk(sys_clk), .rst(rst), .stall(stall), .out_valid(out_valid),
      .out_ready(out_ready), .out_word(out_word));

   // ==========================================
   // Clock, hang limit, done pulse counter
   initial
   begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      cyc++;
      if (done === 1'b1)
         dones++;
      if (cyc == 40000)
      begin
         miss("timeout");
         results();
      end
   end

   // ==========================================
   // Helpers
   task miss(string m);
      err_total++;
      $display("MISMATCH t=%0t %s", $time, m);
   endtask
   task results;
      $display("Errors: %0d, checks: %0d", err_total, samples_checked);
      if (err_total == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Control vector is {defaults, init, arm, trig, sample_valid}
   task step(input logic [4:0] c, input was_samp_t s);
      @(posedge sys_clk);
      {cmd_defaults, cmd_init, arm_in, trig_in, samp_valid} <= c;
      samp <= s;
   endtask
   task idle(int n);
      repeat (n) step(5'h00, '0);
      #1;
   endtask
   task wait_ph(was_state_t p);
      int k;
      k = 0;
      while (phase !== p && k < 2000)
      begin
         idle(1);
         k++;
      end
      `CHK(phase, p, "phase wait")
   endtask
   function was_samp_t smp(int a, int i);
      for (int c = 0; c < 4; c++)
         smp[c] = 8'(16 * c + 3 * i + a);
   endfunction
   function logic [35:0] ev(was_mode_t m, int n, int len, int r, int c, int i);
      int j;
      j = ((i ^ 1) < len) ? (i ^ 1) : i;
      case (m)
         md_norm: ev = 36'(16 * c + 3 * i + r);
         md_avg: ev = 36'(n * (16 * c + 3 * i) + n * (n - 1) / 2);
         default:
         begin
            if (i % 2 == 0)
               ev = 36'(16 * c + 3 * ((i > j) ? i : j) + n - 1);
            else
               ev = 36'(16 * c + 3 * ((i < j) ? i : j));
         end
      endcase
   endfunction
   function logic [35:0] dec(was_mode_t m, logic [19:0] w);
      dec = (m == md_avg) ? (36'(w[15:0]) << w[19:16]) : 36'(w);
   endfunction

   // ==========================================
   // One acquisition: pretrigger fill, arm, trigger, posttrigger fill
   task acq(int a, int pre, int len, logic armed);
      wait_ph(st_pre);
      `CHK(busy, 1'b1, "busy")
      for (int i = 0; i < pre; i++) step(5'h01, smp(a, i));
      if (armed)
      begin
         idle(3);
         `CHK(phase, st_pre, "enabled before arm")
         step(5'h02, '0);
         idle(2);
         `CHK(phase, st_pre, "early trigger taken")
         step(5'h04, '0);
      end
      wait_ph(st_trig);
      for (int i = pre; i < len; i++)
      begin
         step((i == pre) ? 5'h03 : 5'h01, smp(a, i));
         if (i == pre)
         begin
            tdiff = $time - tprev;
            tprev = $time;
         end
      end
      idle(1);
   endtask

   // Setup, initiate, acquire all records, then check the delivered words
   task run(was_mode_t m, int n, int aa, int pre, int len, logic armed, logic hold);
      int k, nacq, words;
      was_mode_t em;
      was_word_t wd;
      logic [35:0] ex;
      nacq = (aa > 0) ? aa : n;
      words = ((aa > 0) ? aa : 1) * len;
      em = (aa > 0) ? md_norm : m;
      host.got_q.delete();
      dones = 0;
      @(posedge sys_clk);
      stall <= hold;
      cfg <= '{interval_ns: '0, rec_len: 15'(len), pre_len: 15'(pre), mode: m,
         auto_adv: (aa > 0), comb_cnt: 13'(n), aa_cnt: 16'(aa), arm_en: armed,
         ch_en: (aa > 0) ? 4'h7 : 4'hF};
      step(5'h08, '0);
      for (int a = 0; a < nacq; a++) acq(a, pre, len, armed);
      if (hold)
      begin
         idle(120);
         `CHK({phase, out_valid}, {st_out, 1'b1}, "fifo full stall")
         @(posedge sys_clk);
         stall <= 1'b0;
      end
      k = 0;
      while (host.got_q.size() < words && k < 3000)
      begin
         idle(1);
         k++;
      end
      idle(4);
      `CHK(host.got_q.size(), words, "word count")
      `CHK(dones, 1, "done pulses")
      `CHK(out_valid, 1'b0, "fifo not drained")
      foreach (host.got_q[w])
      begin
         wd = host.got_q[w];
         `CHK(wd.idx, 15'(w % len), "index")
         if (aa == 0)
            `CHK(wd.last, (w % len == len - 1), "last flag")
         for (int c = 0; c < 4; c++)
         begin
            ex = (aa > 0 && c == 3) ? 36'h0 : ev(em, n, len, w / len, c, w % len);
            `CHK(dec(em, wd.val[c]), ex, "val")
         end
      end
   endtask

   // ==========================================
   // Main sequence
   initial
   begin
      {rst, ce, cmd_init, cmd_defaults, arm_in, trig_in, samp_valid, stall} = 8'hC0;
      samp = '0;
      cfg = '0;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      #1;
      `CHK(ctl_out, CTL_IDLE, "reset")
      for (int k = 0; k < 3; k++)
      begin
         @(posedge sys_clk);
         cfg.interval_ns <= 32'(iv[k]);
         cfg.rec_len <= 15'(ln[k]);
         step(5'h08, '0);
         idle(1);
         `CHK(ext_mode, (k > 0), "sample mode")
         `CHK(eff_len, (k > 0) ? `WAS_ERT_MAX : `WAS_RT_MAX, "length")
      end
      step(5'h10, '0);
      idle(1);
      `CHK(ctl_out, CTL_IDLE, "defaults")
      @(posedge sys_clk);
      ce <= 1'b0;
      step(5'h08, '0);
      idle(2);
      `CHK(ctl_out, CTL_IDLE, "clock enable freeze")
      @(posedge sys_clk);
      ce <= 1'b1;
      run(md_norm, 1, 0, 2, 20, 1'b1, 1'b1);
      run(md_avg, 2, 0, 1, 4, 1'b1, 1'b0);
      run(md_peak, 1, 0, 0, 3, 1'b1, 1'b0);
      run(md_env, 2, 0, 1, 4, 1'b1, 1'b0);
      run(md_avg, 2, 2, 1, 2, 1'b0, 1'b0);
      tsns = longint'(stamp) * `WAS_TS_RES_NS;
      `CHK((tsns > tdiff - `WAS_TS_RES_NS) && (tsns < tdiff + `WAS_TS_RES_NS), 1'b1, "stamp")
      results();
   end
endmodule
